// >>> core/vrc_codec.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Pauses of either modulation depth arrive as one digital pause level.
// - In 1-of-256 mode one pause among 256 slots carries a byte.
// - First slot decodes to 00h, last slot to FFh, linear between.
// - In 1-of-4 mode one pause in four slots gives two bits, LSB pair first.
// - Start-of-frame gap selects the decoding mode for each frame.
// - Frames are bounded by code violations that data never produces.
// - Receiver is ready again 311.5 us after a response ends.
// - Receiver is ready 0.1 ms after the field powers the tag.
// - First header bit picks one or two subcarriers, carrier/32 and carrier/28.
// - Subcarrier switches keep phase continuous.
// - Second header bit picks low or high rate; fast commands double it.
// - Bit periods follow from pulse counts of each rate and subcarrier mode.
// - Manchester bits; low rate times four, fast commands halved.
// - High rate single: zero is pulses then quiet, one the reverse.
// - Fast high rate single: four pulses and 9.44 us quiet per half.
// - Low rate single: 32 pulses or 75.52 us; fast halves those.
// - High rate dual: 8 primary and 9 secondary pulses, order by bit.
// - Low rate dual: 32 primary and 36 secondary pulses, order by bit.
// - Fast commands never use two subcarriers.
// - Response start: quiet (27 secondary pulses if dual), 24 primary pulses, then a logic one.
module vrc_codec #(
  parameter int PWRUP_CYC = vrc_pkg::POWERUP_CYC,
  parameter int GUARD_CYC = vrc_pkg::GUARD_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CARR_CLK,
  input wire logic PAUSE_N,
  input wire logic RF_FIELD,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic RX_SOF,
  output logic RX_MODE,
  output logic RX_EOF,
  output logic RX_ERR,
  output logic RX_READY,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST,
  input wire logic TX_DUAL,
  input wire logic TX_HIGH,
  input wire logic TX_FAST,
  output logic TX_READY,
  output logic TX_BUSY,
  output logic LOAD_MOD
);
  // ****************************************
  // Functions
  // ****************************************
  // Pulses per half-bit for rate and fast selection
  function automatic logic [7:0] unit_of(input logic high, input logic fast);
    unit_of = high ? (fast ? vrc_pkg::UNIT_FAST_HIGH : vrc_pkg::UNIT_HIGH)
                   : (fast ? vrc_pkg::UNIT_FAST_LOW : vrc_pkg::UNIT_LOW);
  endfunction

  // Segment length; secondary carrier needs 9 per 8 primary
  function automatic logic [7:0] seg_len(input logic sec, input logic mult3, input logic [7:0] unit);
    logic [7:0] base;
    base = mult3 ? 8'((unit << 1) + unit) : unit;
    seg_len = sec ? 8'(base + (base >> 3)) : base;
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic car_s1_ff, car_s2_ff, car_s3_ff;
  logic pau_s1_ff, pau_s2_ff, pau_s3_ff;
  logic fld_s1_ff, fld_s2_ff;
  logic ctick;
  logic pfall;

  // Two flops per pin, a third for edges
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      {car_s1_ff, car_s2_ff, car_s3_ff} <= 3'h0;
      {pau_s1_ff, pau_s2_ff, pau_s3_ff} <= 3'h7;
      {fld_s1_ff, fld_s2_ff} <= 2'h0;
    end
    else
    begin
      {car_s1_ff, car_s2_ff, car_s3_ff} <= {CARR_CLK, car_s1_ff, car_s2_ff};
      {pau_s1_ff, pau_s2_ff, pau_s3_ff} <= {PAUSE_N, pau_s1_ff, pau_s2_ff};
      {fld_s1_ff, fld_s2_ff} <= {RF_FIELD, fld_s1_ff};
    end
  end

  // One carrier tick per link clock rise; pause start at fall
  assign ctick = car_s2_ff && !car_s3_ff;
  assign pfall = !pau_s2_ff && pau_s3_ff;

  // ****************************************
  // Readiness timers
  // ****************************************
  logic [vrc_pkg::TMR_W-1:0] pwr_ff, nxt_pwr;
  logic [vrc_pkg::TMR_W-1:0] grd_ff, nxt_grd;
  logic pwr_done;
  logic grd_load;
  logic tx_idle;
  logic rx_ok;

  // Power-up wait restarts whenever the field drops
  assign pwr_done = (pwr_ff == PWRUP_CYC[vrc_pkg::TMR_W-1:0]);
  assign nxt_pwr = !fld_s2_ff ? '0 : pwr_done ? pwr_ff : pwr_ff + 1'b1;
  // Guard after a response frame
  assign nxt_grd = grd_load ? GUARD_CYC[vrc_pkg::TMR_W-1:0]
                 : (grd_ff != '0) ? grd_ff - 1'b1 : grd_ff;
  assign rx_ok = pwr_done && (grd_ff == '0) && tx_idle;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pwr_ff <= '0;
      grd_ff <= '0;
    end
    else
    begin
      pwr_ff <= nxt_pwr;
      grd_ff <= nxt_grd;
    end
  end

  // ****************************************
  // Receive decoder
  // ****************************************
  vrc_pkg::vrc_rx_e rx_st_ff, nxt_rx_st;
  logic [10:0] gap_ff, nxt_gap;
  logic [7:0] tick_ff, nxt_tick;
  logic [7:0] slot_ff, nxt_slot;
  logic [7:0] val_ff, nxt_val;
  logic [7:0] sh_ff, nxt_sh;
  logic [1:0] sym_ff, nxt_sym;
  logic got_ff, nxt_got;
  logic mode_ff, nxt_mode;
  logic [7:0] rdat_ff, nxt_rdat;
  logic rval_ff, nxt_rval;
  logic rsof_ff, nxt_rsof;
  logic reof_ff, nxt_reof;
  logic rerr_ff, nxt_rerr;
  logic [7:0] sym_last;
  logic slot_end;
  logic sym_end;

  assign sym_last = mode_ff ? vrc_pkg::SYM4_LAST : vrc_pkg::SYM256_LAST;
  assign slot_end = ctick && (tick_ff == vrc_pkg::SLOT_LAST);
  assign sym_end = slot_end && (slot_ff == sym_last);

  // Frame walk: start gap, tail, then slots
  always_comb
  begin
    nxt_rx_st = rx_st_ff;
    nxt_gap = gap_ff;
    nxt_tick = ctick ? tick_ff + 8'h01 : tick_ff;
    nxt_slot = slot_end ? slot_ff + 8'h01 : slot_ff;
    nxt_val = val_ff;
    nxt_sh = sh_ff;
    nxt_sym = sym_ff;
    nxt_got = got_ff;
    nxt_mode = mode_ff;
    nxt_rdat = rdat_ff;
    nxt_rval = 1'b0;
    nxt_rsof = 1'b0;
    nxt_reof = 1'b0;
    nxt_rerr = 1'b0;
    if (!rx_ok)
    begin
      nxt_rx_st = vrc_pkg::RX_IDLE;
    end
    else
    begin
      unique case (rx_st_ff)
        vrc_pkg::RX_IDLE:
        begin
          nxt_gap = 11'h000;
          if (pfall)
          begin
            nxt_rx_st = vrc_pkg::RX_SOF;
          end
        end
        vrc_pkg::RX_SOF:
        begin
          if (pfall && gap_ff >= vrc_pkg::SOF_MIN)
          begin
            nxt_mode = (gap_ff >= vrc_pkg::SOF_SPLIT);
            nxt_rsof = 1'b1;
            nxt_tick = 8'h00;
            nxt_rx_st = vrc_pkg::RX_TAIL;
          end
          else if (pfall || gap_ff == vrc_pkg::SOF_MAX)
          begin
            nxt_rerr = 1'b1;
            nxt_rx_st = vrc_pkg::RX_IDLE;
          end
          else if (ctick)
          begin
            nxt_gap = gap_ff + 11'h001;
          end
        end
        vrc_pkg::RX_TAIL:
        begin
          if (ctick && tick_ff == vrc_pkg::SOF_TAIL)
          begin
            nxt_rx_st = vrc_pkg::RX_DATA;
            nxt_slot = 8'h00;
            nxt_sym = 2'h0;
            nxt_got = 1'b0;
          end
        end
        vrc_pkg::RX_DATA:
        begin
          if (pfall && tick_ff < vrc_pkg::HALF_SLOT)
          begin
            // First-half pause is a violation: frame end
            nxt_reof = !got_ff && (sym_ff == 2'h0);
            nxt_rerr = got_ff || (sym_ff != 2'h0);
            nxt_rx_st = vrc_pkg::RX_IDLE;
          end
          else if (pfall && got_ff)
          begin
            nxt_rerr = 1'b1;
            nxt_rx_st = vrc_pkg::RX_IDLE;
          end
          else if (pfall)
          begin
            nxt_got = 1'b1;
            nxt_val = slot_ff;
          end
          else if (sym_end && !got_ff)
          begin
            nxt_rerr = 1'b1;
            nxt_rx_st = vrc_pkg::RX_IDLE;
          end
          else if (sym_end)
          begin
            nxt_slot = 8'h00;
            nxt_got = 1'b0;
            if (mode_ff)
            begin
              nxt_sh = {val_ff[1:0], sh_ff[7:2]};
              nxt_sym = sym_ff + 2'h1;
              nxt_rdat = {val_ff[1:0], sh_ff[7:2]};
              nxt_rval = (sym_ff == vrc_pkg::PAIRS_LAST);
            end
            else
            begin
              nxt_rdat = val_ff;
              nxt_rval = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      rx_st_ff <= vrc_pkg::RX_IDLE;
      {gap_ff, tick_ff, slot_ff, val_ff, sh_ff} <= '0;
      {sym_ff, got_ff, mode_ff, rdat_ff} <= '0;
      {rval_ff, rsof_ff, reof_ff, rerr_ff} <= 4'h0;
    end
    else
    begin
      rx_st_ff <= nxt_rx_st;
      {gap_ff, tick_ff, slot_ff, val_ff, sh_ff} <= {nxt_gap, nxt_tick, nxt_slot, nxt_val, nxt_sh};
      {sym_ff, got_ff, mode_ff, rdat_ff} <= {nxt_sym, nxt_got, nxt_mode, nxt_rdat};
      {rval_ff, rsof_ff, reof_ff, rerr_ff} <= {nxt_rval, nxt_rsof, nxt_reof, nxt_rerr};
    end
  end

  assign RX_DATA = rdat_ff;
  assign RX_VALID = rval_ff;
  assign RX_SOF = rsof_ff;
  assign RX_MODE = mode_ff;
  assign RX_EOF = reof_ff;
  assign RX_ERR = rerr_ff;
  assign RX_READY = rx_ok && (rx_st_ff == vrc_pkg::RX_IDLE);

  // ****************************************
  // Transmit encoder
  // ****************************************
  vrc_pkg::vrc_tx_e tx_st_ff, nxt_tx_st;
  logic [1:0] kind_ff, nxt_kind;
  logic [2:0] idx_ff, nxt_idx;
  logic [7:0] byte_ff, nxt_byte;
  logic last_ff, nxt_last;
  logic dual_ff, nxt_dual;
  logic high_ff, nxt_high;
  logic fast_ff, nxt_fast;
  logic seg_start_ff, seg_sec_ff, seg_mod_ff;
  logic [7:0] seg_cnt_ff;
  logic can_tx;
  logic seg_done;
  logic adv;
  logic nxt_bit;
  logic pri_seg;
  logic mult3;
  logic more;
  vrc_seg_if sg ();

  assign tx_idle = (tx_st_ff == vrc_pkg::TX_IDLE);
  assign can_tx = pwr_done && (rx_st_ff == vrc_pkg::RX_IDLE);
  assign seg_done = sg.done;
  assign more = (idx_ff == vrc_pkg::BIT_LAST) && !last_ff && (kind_ff == 2'h1);

  // Frame order: start, marker one, data, marker zero, end
  always_comb
  begin
    nxt_tx_st = tx_st_ff;
    nxt_kind = kind_ff;
    nxt_idx = idx_ff;
    nxt_byte = byte_ff;
    nxt_last = last_ff;
    nxt_dual = dual_ff;
    nxt_high = high_ff;
    nxt_fast = fast_ff;
    grd_load = 1'b0;
    unique case (tx_st_ff)
      vrc_pkg::TX_IDLE:
      begin
        if (TX_VALID && can_tx)
        begin
          nxt_byte = TX_DATA;
          nxt_last = TX_LAST;
          nxt_dual = TX_DUAL && !TX_FAST;
          nxt_high = TX_HIGH;
          nxt_fast = TX_FAST;
          nxt_tx_st = vrc_pkg::TX_SOFA;
        end
      end
      vrc_pkg::TX_SOFA:
        if (seg_done) nxt_tx_st = vrc_pkg::TX_SOFB;
      vrc_pkg::TX_SOFB:
      begin
        if (seg_done)
        begin
          nxt_kind = 2'h0;
          nxt_tx_st = vrc_pkg::TX_BITA;
        end
      end
      vrc_pkg::TX_BITA:
        if (seg_done) nxt_tx_st = vrc_pkg::TX_BITB;
      vrc_pkg::TX_BITB:
      begin
        if (seg_done)
        begin
          nxt_tx_st = vrc_pkg::TX_BITA;
          nxt_idx = 3'h0;
          if (kind_ff == 2'h0)
          begin
            nxt_kind = 2'h1;
          end
          else if (kind_ff == 2'h2)
          begin
            nxt_tx_st = vrc_pkg::TX_EOFC;
          end
          else if (idx_ff != vrc_pkg::BIT_LAST)
          begin
            nxt_byte = {1'b0, byte_ff[7:1]}; // Least significant bit first
            nxt_idx = idx_ff + 3'h1;
          end
          else if (more && TX_VALID)
          begin
            nxt_byte = TX_DATA;
            nxt_last = TX_LAST;
          end
          else
          begin
            nxt_kind = 2'h2; // Last byte or underrun closes frame
          end
        end
      end
      vrc_pkg::TX_EOFC:
        if (seg_done) nxt_tx_st = vrc_pkg::TX_EOFD;
      vrc_pkg::TX_EOFD:
      begin
        if (seg_done)
        begin
          grd_load = 1'b1;
          nxt_tx_st = vrc_pkg::TX_IDLE;
        end
      end
      default:
        nxt_tx_st = vrc_pkg::TX_IDLE;
    endcase
  end

  // Pick the next segment from the next state and bit
  assign adv = (tx_idle && TX_VALID && can_tx) || (!tx_idle && seg_done);
  assign nxt_bit = (nxt_kind == 2'h0) ? 1'b1 : (nxt_kind == 2'h2) ? 1'b0 : nxt_byte[0];
  assign pri_seg = (nxt_tx_st == vrc_pkg::TX_SOFB) || (nxt_tx_st == vrc_pkg::TX_EOFC)
                || ((nxt_tx_st == vrc_pkg::TX_BITA) && !nxt_bit)
                || ((nxt_tx_st == vrc_pkg::TX_BITB) && nxt_bit);
  assign mult3 = (nxt_tx_st != vrc_pkg::TX_BITA) && (nxt_tx_st != vrc_pkg::TX_BITB);

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      tx_st_ff <= vrc_pkg::TX_IDLE;
      {kind_ff, idx_ff, byte_ff, last_ff} <= '0;
      {dual_ff, high_ff, fast_ff} <= 3'h0;
      {seg_start_ff, seg_sec_ff, seg_mod_ff, seg_cnt_ff} <= '0;
    end
    else
    begin
      tx_st_ff <= nxt_tx_st;
      {kind_ff, idx_ff, byte_ff, last_ff} <= {nxt_kind, nxt_idx, nxt_byte, nxt_last};
      {dual_ff, high_ff, fast_ff} <= {nxt_dual, nxt_high, nxt_fast};
      seg_start_ff <= adv && (nxt_tx_st != vrc_pkg::TX_IDLE);
      if (adv)
      begin
        seg_sec_ff <= !pri_seg && nxt_dual;
        seg_mod_ff <= pri_seg || nxt_dual;
        seg_cnt_ff <= seg_len(!pri_seg && nxt_dual, mult3, unit_of(nxt_high, nxt_fast));
      end
    end
  end

  // Segment generator keeps subcarrier phase across switches
  assign sg.ctick = ctick;
  assign sg.start = seg_start_ff;
  assign sg.sec = seg_sec_ff;
  assign sg.modul = seg_mod_ff;
  assign sg.npulse = seg_cnt_ff;

  vrc_seg_gen u_seg (
    .clk (CLK),
    .rst (RST),
    .sg (sg.enc)
  );

  assign TX_READY = (tx_idle && can_tx)
                 || ((tx_st_ff == vrc_pkg::TX_BITB) && seg_done && more);
  assign TX_BUSY = !tx_idle;
  assign LOAD_MOD = sg.mod;
endmodule
`default_nettype wire

// >>> core/vrc_seg_gen.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Segment generator: N subcarrier periods
// ****************************************
module vrc_seg_gen (
  input wire logic clk,
  input wire logic rst,
  vrc_seg_if.enc sg
);
  logic act_ff;
  logic sec_ff;
  logic modul_ff;
  logic [4:0] ph_ff;
  logic [7:0] cnt_ff;
  logic done_ff;
  logic mod_ff;
  logic [4:0] ph_last;
  logic [4:0] ph_half;
  logic per_end;

  // Period length follows the selected subcarrier
  assign ph_last = sec_ff ? vrc_pkg::SUB2_LAST : vrc_pkg::SUB1_LAST;
  assign ph_half = sec_ff ? vrc_pkg::SUB2_HALF : vrc_pkg::SUB1_HALF;
  assign per_end = act_ff && sg.ctick && (ph_ff == ph_last);
  assign sg.done = done_ff;
  assign sg.mod = mod_ff;

  // Count ticks and periods; a new start resumes with no gap
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      act_ff <= 1'b0;
      sec_ff <= 1'b0;
      modul_ff <= 1'b0;
      ph_ff <= 5'h00;
      cnt_ff <= 8'h00;
      done_ff <= 1'b0;
      mod_ff <= 1'b0;
    end
    else
    begin
      done_ff <= per_end && (cnt_ff == 8'h01);
      mod_ff <= act_ff && modul_ff && (ph_ff < ph_half);
      if (sg.start)
      begin
        act_ff <= 1'b1;
        sec_ff <= sg.sec;
        modul_ff <= sg.modul;
        ph_ff <= 5'h00;
        cnt_ff <= sg.npulse;
      end
      else if (per_end)
      begin
        ph_ff <= 5'h00;
        cnt_ff <= cnt_ff - 8'h01;
        act_ff <= (cnt_ff != 8'h01);
      end
      else if (act_ff && sg.ctick)
      begin
        ph_ff <= ph_ff + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> pkg/vrc_pkg.sv
// ****************************************
// Shared constants and types
// ****************************************
package vrc_pkg;
  // System clock rate
  localparam int CLK_MHZ = 50;
  // Power-up delay and post-response guard, in ns
  localparam int POWERUP_NS = 100000;
  localparam int GUARD_NS = 311500;
  // Least times round up to whole clock cycles
  localparam int POWERUP_CYC = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int GUARD_CYC = (GUARD_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 16;
  // Receive slot timing in carrier ticks, symbol lengths in slots
  localparam logic [7:0] SLOT_LAST = 8'hff;
  localparam logic [7:0] HALF_SLOT = 8'h80;
  localparam logic [7:0] SYM256_LAST = 8'hff;
  localparam logic [7:0] SYM4_LAST = 8'h03;
  localparam logic [1:0] PAIRS_LAST = 2'h3;
  // Gap between the two reader start pauses, then the tail after the second
  localparam logic [10:0] SOF_MIN = 11'h200;
  localparam logic [10:0] SOF_SPLIT = 11'h380;
  localparam logic [10:0] SOF_MAX = 11'h500;
  localparam logic [7:0] SOF_TAIL = 8'hff;
  // Subcarrier periods, in carrier ticks
  localparam logic [4:0] SUB1_LAST = 5'h1f;
  localparam logic [4:0] SUB1_HALF = 5'h10;
  localparam logic [4:0] SUB2_LAST = 5'h1b;
  localparam logic [4:0] SUB2_HALF = 5'h0e;
  // Pulses per half-bit for each rate, and last bit index of a byte
  localparam logic [7:0] UNIT_HIGH = 8'h08;
  localparam logic [7:0] UNIT_LOW = 8'h20;
  localparam logic [7:0] UNIT_FAST_HIGH = 8'h04;
  localparam logic [7:0] UNIT_FAST_LOW = 8'h10;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Receive states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_SOF = 2'b01,
    RX_TAIL = 2'b10,
    RX_DATA = 2'b11
  } vrc_rx_e;
  // Transmit states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_SOFA = 3'b001,
    TX_SOFB = 3'b010,
    TX_BITA = 3'b011,
    TX_BITB = 3'b100,
    TX_EOFC = 3'b101,
    TX_EOFD = 3'b110
  } vrc_tx_e;
endpackage

// >>> pkg/vrc_seg_if.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Subcarrier segment request bundle
// ****************************************
interface vrc_seg_if;
  logic ctick;
  logic start;
  logic sec;
  logic modul;
  logic [7:0] npulse;
  logic done;
  logic mod;
  modport drv (output ctick, start, sec, modul, npulse, input done, mod);
  modport enc (input ctick, start, sec, modul, npulse, output done, mod);
endinterface
`default_nettype wire

// >>> verif/vrc_codec_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Port checker
// ********
module vrc_codec_assertions #(
  parameter int PWRUP_CYC = 50,
  parameter int GUARD_CYC = 100
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RF_FIELD,
  input wire logic RX_VALID,
  input wire logic RX_SOF,
  input wire logic RX_MODE,
  input wire logic RX_EOF,
  input wire logic RX_ERR,
  input wire logic RX_READY,
  input wire logic TX_READY,
  input wire logic TX_BUSY,
  input wire logic LOAD_MOD
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  int fld_ff;
  int gap_ff;
  int hi_ff;
  // Field age, cycles since a response, length of load-on
  always_ff @(posedge CLK)
  begin
    fld_ff <= (RST || !RF_FIELD) ? 0 : ((fld_ff < PWRUP_CYC) ? fld_ff + 1 : fld_ff);
    gap_ff <= RST ? GUARD_CYC : (TX_BUSY ? 0 : ((gap_ff < GUARD_CYC) ? gap_ff + 1 : gap_ff));
    hi_ff <= LOAD_MOD ? hi_ff + 1 : 0;
  end
  a_valid_one_cycle: assert property (RX_VALID |=> !RX_VALID)
    else $error("byte strobe longer than one cycle");
  a_valid_not_tx: assert property (RX_VALID |-> !TX_BUSY)
    else $error("byte received while sending");
  a_sof_one_cycle: assert property (RX_SOF |=> !RX_SOF)
    else $error("start strobe longer than one cycle");
  a_mode_with_sof: assert property ($changed(RX_MODE) |-> RX_SOF)
    else $error("coding mode changed outside a start");
  a_eof_clean: assert property (RX_EOF |-> !RX_ERR ##1 !RX_EOF)
    else $error("end strobe malformed");
  a_ready_powerup: assert property ((RX_READY || TX_READY) |-> fld_ff >= PWRUP_CYC)
    else $error("ready before power-up delay");
  a_guard_rx: assert property (RX_READY |-> !TX_BUSY && gap_ff >= GUARD_CYC - 1)
    else $error("receiver ready too early after response");
  a_quiet_idle: assert property ((!TX_BUSY) [*3] |-> !LOAD_MOD)
    else $error("load on outside a response");
  a_pulse_width: assert property ($fell(LOAD_MOD) |-> hi_ff inside {[104:136]})
    else $error("subcarrier half period wrong");
endmodule
bind vrc_codec vrc_codec_assertions #(.PWRUP_CYC(PWRUP_CYC), .GUARD_CYC(GUARD_CYC)) u_chk (
  .CLK(CLK), .RST(RST), .RF_FIELD(RF_FIELD), .RX_VALID(RX_VALID), .RX_SOF(RX_SOF),
  .RX_MODE(RX_MODE), .RX_EOF(RX_EOF), .RX_ERR(RX_ERR), .RX_READY(RX_READY),
  .TX_READY(TX_READY), .TX_BUSY(TX_BUSY), .LOAD_MOD(LOAD_MOD)
);
`default_nettype wire

// >>> verif/vrc_codec_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module vrc_codec_tb_top;
  logic clk, rst, carr_clk, pause_n, field, lm_q;
  logic [7:0] rx_data, tx_data, last_data;
  logic rx_valid, rx_sof, rx_mode, rx_eof, rx_err, rx_ready, last_mode;
  logic tx_valid, tx_last, tx_dual, tx_high, tx_fast, tx_ready, tx_busy, load_mod;
  int err_count = 0;
  int checked = 0;
  int n_sof, n_val, n_eof, n_err, n_mod;
  // ********
  // Clock, reader and design
  // ********
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  vrc_reader_model rdr (.carr_clk(carr_clk), .pause_n(pause_n));
  vrc_codec #(.PWRUP_CYC(50), .GUARD_CYC(100)) dut (
    .CLK(clk), .RST(rst), .CARR_CLK(carr_clk), .PAUSE_N(pause_n), .RF_FIELD(field),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_SOF(rx_sof), .RX_MODE(rx_mode),
    .RX_EOF(rx_eof), .RX_ERR(rx_err), .RX_READY(rx_ready), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_LAST(tx_last), .TX_DUAL(tx_dual), .TX_HIGH(tx_high),
    .TX_FAST(tx_fast), .TX_READY(tx_ready), .TX_BUSY(tx_busy), .LOAD_MOD(load_mod)
  );
  // Event counters, sampled on settled values
  always @(negedge clk)
  begin
    n_sof += int'(rx_sof === 1'b1);
    n_val += int'(rx_valid === 1'b1);
    n_eof += int'(rx_eof === 1'b1);
    n_err += int'(rx_err === 1'b1);
    n_mod += int'(load_mod === 1'b1 && lm_q === 1'b0);
    lm_q = load_mod;
    if (rx_valid === 1'b1) last_data = rx_data;
    if (rx_sof === 1'b1) last_mode = rx_mode;
  end
  // ********
  // Shared tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic clr();
    n_sof = 0;
    n_val = 0;
    n_eof = 0;
    n_err = 0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_powerup();
    int n;
    n = 0;
    repeat (200) @(negedge clk);
    check(rx_ready, 1'b0, "ready without field");
    @(posedge clk);
    field <= 1'b1;
    while (rx_ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check(n >= 50 && n <= 60, 1, "power-up delay");
    $display("test powerup done");
  endtask
  task automatic t_rx(input int gap, input logic four, input logic nb, input logic [7:0] b);
    clr();
    rdr.frame(gap, four, nb, b);
    repeat (20) @(negedge clk);
    check(n_sof, 1, "start count");
    check(last_mode, four, "coding mode");
    check(n_val, nb, "byte count");
    if (nb) check(last_data, b, "byte value");
    check(n_eof, 1, "end count");
    check(n_err, 0, "error count");
    $display("test receive gap %0d done", gap);
  endtask
  task automatic t_tx();
    logic [31:0] exp, seen;
    logic [15:0] d;
    logic act;
    int n;
    n = 0;
    d = '0;
    seen = '0;
    for (int i = 0; i < 8; i++)
      d = {d[13:0], tx_data[i] ? 2'b01 : 2'b10};
    exp = {8'b00011101, d, 8'b10111000};
    @(posedge clk);
    tx_valid <= 1'b1;
    while (tx_ready !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    tx_valid <= 1'b0;
    while (tx_busy !== 1'b1 && n < 20100)
    begin
      @(negedge clk);
      n++;
    end
    n_mod = 0;
    for (int k = 0; k < 32; k++)
    begin
      act = 1'b0;
      repeat (64) @(negedge clk);
      repeat (896)
      begin
        @(negedge clk);
        act = act | (load_mod === 1'b1);
      end
      repeat (64) @(negedge clk);
      seen = {seen[30:0], act};
    end
    check(seen, exp, "half-bit pattern");
    check(n_mod, 64, "subcarrier pulses");
    n = 0;
    while (tx_busy !== 1'b0 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    check(tx_busy, 1'b0, "frame length");
    repeat (50) @(negedge clk);
    check(rx_ready, 1'b0, "guard active");
    repeat (60) @(negedge clk);
    check(rx_ready, 1'b1, "ready after guard");
    $display("test transmit done");
  endtask
  task automatic t_badgap();
    clr();
    rdr.frame(300, 1'b0, 1'b0, 8'h00);
    repeat (11000) @(negedge clk);
    check(n_err != 0, 1, "bad start flagged");
    check(n_sof, 0, "bad start refused");
    $display("test bad start done");
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    field = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h4b;
    tx_last = 1'b1;
    tx_dual = 1'b1;
    tx_high = 1'b1;
    tx_fast = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_powerup();
    t_rx(640, 1'b0, 1'b0, 8'h00);
    t_rx(1024, 1'b1, 1'b1, 8'he1);
    t_tx();
    t_badgap();
    stop_test();
  end
  // Watchdog
  initial
  begin
    repeat (150000) @(posedge clk);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire

// >>> verif/vrc_reader_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Reader model: carrier ticks and pauses
// ********
module vrc_reader_model (
  output logic carr_clk,
  output logic pause_n
);
  // Free-running carrier, phase unrelated to the system clock
  initial
  begin
    carr_clk = 1'b0;
    pause_n = 1'b1;
    #7;
    forever #80 carr_clk = ~carr_clk;
  end
  // Wait carrier ticks
  task automatic ticks(input int n);
    repeat (n) @(posedge carr_clk);
  endtask
  // One pause, same digital level for either depth
  task automatic pause();
    pause_n <= 1'b0;
    ticks(8);
    pause_n <= 1'b1;
  endtask
  // Pause late in slot v of n slots
  task automatic symbol(input int v, input int n);
    ticks(v * 256 + 192);
    pause();
    ticks((n - v) * 256 - 200);
  endtask
  // Start gap, optional byte, end marker in a first half
  task automatic frame(input int gap, input logic four, input logic nb, input logic [7:0] b);
    pause();
    ticks(gap - 8);
    pause();
    ticks(248);
    if (nb && four)
      for (int i = 0; i < 4; i++)
        symbol(int'(b[2 * i +: 2]), 4);
    else if (nb)
      symbol(int'(b), 256);
    ticks(32);
    pause();
    ticks(64);
  endtask
endmodule
`default_nettype wire
